// File: pkg/overlay_cfg.svh
// Register indices, field masks and positions of the overlay register bank
`ifndef OVERLAY_CFG_SVH
`define OVERLAY_CFG_SVH

`define APB_AW 12
`define REG_NUM 17
// Register indices (byte address is four times the index)
`define IDX_BR_MODE 10'h088
`define IDX_BR_ORIGIN0 10'h08C
`define IDX_BR_DISP0 10'h090
`define IDX_BR_ORIGIN1 10'h094
`define IDX_BR_DISP1 10'h098
`define IDX_BR_START_X 10'h09C
`define IDX_BR_START_Y 10'h09E
`define IDX_CUR_TRANSP 10'h0A0
`define IDX_CUR_PRIO 10'h0A2
`define IDX_CUR0_ADDR 10'h0A4
`define IDX_CUR0_X 10'h0A8
`define IDX_CUR0_Y 10'h0AA
`define IDX_CUR1_ADDR 10'h0AC
`define IDX_CUR1_X 10'h0B0
`define IDX_CUR1_Y 10'h0B2
`define IDX_BLEND_CTRL 10'h0B4
`define IDX_BLEND_MODE 10'h0B6
// Writable bits of each register
`define MSK_BR_MODE 32'h8000_0000
`define MSK_ADDR16 32'h0FFF_FFF0
`define MSK_ADDR 32'h0FFF_FFFF
`define MSK_POS 32'h0000_0FFF
`define MSK_TRANSP 32'h0000_01FF
`define MSK_PRIO 32'h0000_0033
`define MSK_BLEND_CTRL 32'h0000_80F0
`define MSK_BLEND_MODE 32'h0000_0001
`define RST_VAL 32'h0000_0000
// Field positions
`define POS_COLOR_MODE 31
`define POS_ZERO_OPAQUE 8
`define POS_CUR0_OVER 0
`define POS_CUR1_OVER 1
`define POS_CUR0_EN 4
`define POS_CUR1_EN 5
`define POS_FORMULA 15
`define POS_COEF_LO 4
`define POS_COEF_HI 7
`define POS_BLEND 0
`define COEF_ONE 5'h10
`define CODE_ZERO 8'h00
`endif

// File: pkg/overlay_pkg.sv
// Types shared by the overlay register bank
`default_nettype none
package overlay_pkg;
  typedef logic [17:0] rgb_t;
  typedef logic [31:0] word_t;
  typedef enum {SEL_LOWER, SEL_CONSOLE, SEL_CUR0, SEL_CUR1} layer_sel_t;
endpackage
`default_nettype wire

// File: src/overlay_cursor_blend_regs.sv
// Overlay register bank on APB with cursor and console compositing stage
//
// Chosen here: register access over APB.
`include "overlay_cfg.svh"
`default_nettype none
// How it works
// [RULE1] Bit 31: 0 indexed 8-bit, 1 direct 16-bit
// [RULE2] Frame origin registers keep low four bits zero
// [RULE3] Direct colour clears display address bit zero
// [RULE4] Start X/Y give pixel offset from frame
// [RULE5] Cursor pixels matching transparent code are hidden
// [RULE6] Bit 8 clear hides code 0, set shows
// [RULE7] Cursor 0 always shown in front of 1
// [RULE8] Bit 0 puts cursor 0 over console
// [RULE9] Bit 1 puts cursor 1 over console
// [RULE10] Bits 4/5 enable cursors; priority bits reset zero
// [RULE11] Cursor pattern addresses keep low four bits zero
// [RULE12] Cursor X gives pattern left edge
// [RULE13] Cursor 0 Y gives pattern top edge
// [RULE14] Cursor 1 Y gives vertical pixel coordinate
// [RULE15] Coefficient is bits 7-4 over sixteen
// [RULE16] Coefficient applies only to blended console pixels
// [RULE17] Select 0: console times k plus rest
// [RULE18] Select 1: console times one minus k
// [RULE19] Blend bit 0 plain priority, 1 blends
// [RULE20] Reserved bits read zero, ignore writes
module overlay_cursor_blend_regs
  import overlay_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CFG_DIRECT_COLOR,
  output logic [31:0] CFG_ORIGIN0,
  output logic [31:0] CFG_DISP_ADDR0,
  output logic [31:0] CFG_ORIGIN1,
  output logic [31:0] CFG_DISP_ADDR1,
  output logic [11:0] CFG_START_X,
  output logic [11:0] CFG_START_Y,
  output logic [31:0] CFG_CUR0_ADDR,
  output logic [11:0] CFG_CUR0_X,
  output logic [11:0] CFG_CUR0_Y,
  output logic [31:0] CFG_CUR1_ADDR,
  output logic [11:0] CFG_CUR1_X,
  output logic [11:0] CFG_CUR1_Y,
  output logic CFG_CUR0_EN,
  output logic CFG_CUR1_EN,
  input wire logic PIX_VALID,
  input wire logic [17:0] LOWER_RGB,
  input wire logic CONSOLE_OPAQUE,
  input wire logic CONSOLE_ALPHA,
  input wire logic [17:0] CONSOLE_RGB,
  input wire logic CUR0_HIT,
  input wire logic [7:0] CUR0_CODE,
  input wire logic [17:0] CUR0_RGB,
  input wire logic CUR1_HIT,
  input wire logic [7:0] CUR1_CODE,
  input wire logic [17:0] CUR1_RGB,
  output logic OUT_VALID,
  output logic [17:0] OUT_RGB
);

  // ----------------------------------------
  // Register table
  // ----------------------------------------
  localparam int NREG = `REG_NUM;
  localparam int E_MODE = 0;
  localparam int E_ORG0 = 1;
  localparam int E_DSP0 = 2;
  localparam int E_ORG1 = 3;
  localparam int E_DSP1 = 4;
  localparam int E_SX = 5;
  localparam int E_SY = 6;
  localparam int E_TRN = 7;
  localparam int E_PRIO = 8;
  localparam int E_C0A = 9;
  localparam int E_C0X = 10;
  localparam int E_C0Y = 11;
  localparam int E_C1A = 12;
  localparam int E_C1X = 13;
  localparam int E_C1Y = 14;
  localparam int E_BCTL = 15;
  localparam int E_BMOD = 16;

  localparam logic [9:0] IDX [NREG] = '{
    `IDX_BR_MODE, `IDX_BR_ORIGIN0, `IDX_BR_DISP0, `IDX_BR_ORIGIN1,
    `IDX_BR_DISP1, `IDX_BR_START_X, `IDX_BR_START_Y, `IDX_CUR_TRANSP,
    `IDX_CUR_PRIO, `IDX_CUR0_ADDR, `IDX_CUR0_X, `IDX_CUR0_Y,
    `IDX_CUR1_ADDR, `IDX_CUR1_X, `IDX_CUR1_Y, `IDX_BLEND_CTRL,
    `IDX_BLEND_MODE
  };

  // Origins and cursor pattern addresses drop their low nibble
  localparam word_t MSK [NREG] = '{
    `MSK_BR_MODE, `MSK_ADDR16, `MSK_ADDR, `MSK_ADDR16,
    `MSK_ADDR, `MSK_POS, `MSK_POS, `MSK_TRANSP,
    `MSK_PRIO, `MSK_ADDR16, `MSK_POS, `MSK_POS,
    `MSK_ADDR16, `MSK_POS, `MSK_POS, `MSK_BLEND_CTRL,
    `MSK_BLEND_MODE
  };

  localparam logic [NREG-1:0] IS_DISP = (NREG'(1) << E_DSP0) | (NREG'(1) << E_DSP1);

  word_t reg_q [NREG];
  word_t reg_d [NREG];
  logic [NREG-1:0] hit;
  logic any_hit;
  logic access;
  logic direct_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  word_t prdata_q;
  word_t prdata_d;
  word_t rd_mux;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Writes take effect in the access cycle in which PREADY is high; read data is sampled one cycle earlier
  assign access = PSEL & PENABLE & pready_q;

  // Colour mode as it will stand after this edge
  assign direct_d = (access & PWRITE & hit[E_MODE]) ? PWDATA[`POS_COLOR_MODE]
                                                    : reg_q[E_MODE][`POS_COLOR_MODE];

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = (PADDR[`APB_AW-1:2] == IDX[gi]);
      always_comb begin
        reg_d[gi] = reg_q[gi];
        if (access & PWRITE & hit[gi]) begin
          reg_d[gi] = PWDATA & MSK[gi]; // [RULE2] [RULE11] [RULE20]
        end
        if (IS_DISP[gi] & direct_d) begin
          reg_d[gi][0] = 1'b0; // [RULE3]
        end
      end
      always_ff @(posedge MCLK) begin
        if (RST) begin
          reg_q[gi] <= `RST_VAL; // [RULE10] [RULE15]
        end else begin
          reg_q[gi] <= reg_d[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_mux = `RST_VAL;
    any_hit = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_mux = rd_mux | reg_q[i];
        any_hit = 1'b1;
      end
    end
  end

  // One wait state: PREADY rises in the second access cycle
  always_comb begin
    pready_d = PSEL & PENABLE & ~pready_q;
    pslverr_d = pready_d & ~any_hit;
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = (any_hit & ~PWRITE) ? rd_mux : `RST_VAL;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `RST_VAL;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // ----------------------------------------
  // Configuration to frame fetch
  // ----------------------------------------
  assign CFG_DIRECT_COLOR = reg_q[E_MODE][`POS_COLOR_MODE]; // [RULE1]
  assign CFG_ORIGIN0 = reg_q[E_ORG0];
  assign CFG_DISP_ADDR0 = reg_q[E_DSP0];
  assign CFG_ORIGIN1 = reg_q[E_ORG1];
  assign CFG_DISP_ADDR1 = reg_q[E_DSP1];
  assign CFG_START_X = reg_q[E_SX][11:0]; // [RULE4]
  assign CFG_START_Y = reg_q[E_SY][11:0]; // [RULE4]
  assign CFG_CUR0_ADDR = reg_q[E_C0A];
  assign CFG_CUR0_X = reg_q[E_C0X][11:0]; // [RULE12]
  assign CFG_CUR0_Y = reg_q[E_C0Y][11:0]; // [RULE13]
  assign CFG_CUR1_ADDR = reg_q[E_C1A];
  assign CFG_CUR1_X = reg_q[E_C1X][11:0]; // [RULE12]
  assign CFG_CUR1_Y = reg_q[E_C1Y][11:0]; // [RULE14]
  assign CFG_CUR0_EN = reg_q[E_PRIO][`POS_CUR0_EN]; // [RULE10]
  assign CFG_CUR1_EN = reg_q[E_PRIO][`POS_CUR1_EN]; // [RULE10]

  // ----------------------------------------
  // Cursor visibility
  // ----------------------------------------
  logic [7:0] tcode;
  logic zero_opaque;
  logic cur0_vis;
  logic cur1_vis;
  logic cur0_over;
  logic cur1_over;
  logic sel_over;
  logic cur_any;
  rgb_t cur_rgb;

  assign tcode = reg_q[E_TRN][7:0];
  assign zero_opaque = reg_q[E_TRN][`POS_ZERO_OPAQUE];
  assign cur0_over = reg_q[E_PRIO][`POS_CUR0_OVER];
  assign cur1_over = reg_q[E_PRIO][`POS_CUR1_OVER];

  function automatic logic cur_shown(input logic h, input logic en, input logic [7:0] code,
                                     input logic [7:0] tc, input logic zo);
    logic clear;
    clear = (code == `CODE_ZERO) ? ~zo : (code == tc); // [RULE5] [RULE6]
    return h & en & ~clear;
  endfunction

  assign cur0_vis = cur_shown(CUR0_HIT, CFG_CUR0_EN, CUR0_CODE, tcode, zero_opaque);
  assign cur1_vis = cur_shown(CUR1_HIT, CFG_CUR1_EN, CUR1_CODE, tcode, zero_opaque);
  // Cursor 0 hides cursor 1 and brings its own console priority
  assign cur_any = cur0_vis | cur1_vis;
  assign cur_rgb = cur0_vis ? CUR0_RGB : CUR1_RGB; // [RULE7]
  assign sel_over = cur0_vis ? cur0_over : cur1_over; // [RULE8] [RULE9]

  // ----------------------------------------
  // Console blend
  // ----------------------------------------
  logic [3:0] coef;
  logic formula;
  logic blend_on;
  logic [4:0] w_con;
  logic [4:0] w_low;
  rgb_t under_rgb;
  rgb_t mix_rgb;

  assign coef = reg_q[E_BCTL][`POS_COEF_HI:`POS_COEF_LO];
  assign formula = reg_q[E_BCTL][`POS_FORMULA];
  assign blend_on = reg_q[E_BMOD][`POS_BLEND];
  // Console weight is k/16 or (16-k)/16
  assign w_con = formula ? (`COEF_ONE - {1'b0, coef}) : {1'b0, coef}; // [RULE15] [RULE17] [RULE18]
  assign w_low = `COEF_ONE - w_con;
  // Combination below the console: a rear cursor or the lower layers
  assign under_rgb = (cur_any & ~sel_over) ? cur_rgb : LOWER_RGB;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      logic [10:0] acc;
      assign acc = 11'(CONSOLE_RGB[gi*6 +: 6] * w_con) + 11'(under_rgb[gi*6 +: 6] * w_low);
      assign mix_rgb[gi*6 +: 6] = acc[9:4];
    end
  endgenerate

  // ----------------------------------------
  // Layer selection and output stage
  // ----------------------------------------
  layer_sel_t sel;
  logic mix_use;
  logic out_valid_d;
  logic out_valid_q;
  rgb_t out_rgb_d;
  rgb_t out_rgb_q;

  always_comb begin
    sel = SEL_LOWER;
    if (cur_any & (sel_over | ~CONSOLE_OPAQUE)) begin
      sel = cur0_vis ? SEL_CUR0 : SEL_CUR1;
    end else if (CONSOLE_OPAQUE) begin
      sel = SEL_CONSOLE;
    end
  end

  assign mix_use = blend_on & CONSOLE_ALPHA; // [RULE16] [RULE19]

  always_comb begin
    out_valid_d = PIX_VALID;
    case (sel)
      SEL_CUR0: out_rgb_d = CUR0_RGB;
      SEL_CUR1: out_rgb_d = CUR1_RGB;
      SEL_CONSOLE: out_rgb_d = mix_use ? mix_rgb : CONSOLE_RGB; // [RULE19]
      SEL_LOWER: out_rgb_d = under_rgb;
      default: out_rgb_d = LOWER_RGB;
    endcase
    if (~PIX_VALID) begin
      out_rgb_d = out_rgb_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      out_valid_q <= 1'b0;
      out_rgb_q <= 18'h00000;
    end else begin
      out_valid_q <= out_valid_d;
      out_rgb_q <= out_rgb_d;
    end
  end

  assign OUT_VALID = out_valid_q;
  assign OUT_RGB = out_rgb_q;

endmodule
`default_nettype wire

// File: verification/overlay_cursor_blend_regs_chk.sv
// Port checker for the overlay register bank
`include "overlay_cfg.svh"
`default_nettype none
module overlay_cursor_blend_regs_chk
  import overlay_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CFG_DIRECT_COLOR,
  input wire logic [31:0] CFG_ORIGIN0,
  input wire logic [31:0] CFG_ORIGIN1,
  input wire logic [31:0] CFG_DISP_ADDR0,
  input wire logic [31:0] CFG_DISP_ADDR1,
  input wire logic [31:0] CFG_CUR0_ADDR,
  input wire logic [31:0] CFG_CUR1_ADDR,
  input wire logic CFG_CUR0_EN,
  input wire logic CFG_CUR1_EN,
  input wire logic PIX_VALID,
  input wire logic [17:0] LOWER_RGB,
  input wire logic CONSOLE_OPAQUE,
  input wire logic CONSOLE_ALPHA,
  input wire logic [17:0] CONSOLE_RGB,
  input wire logic CUR0_HIT,
  input wire logic CUR1_HIT,
  input wire logic [17:0] OUT_RGB
);
  // ----------------------------------------
  // Bus and compositing checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_acc;
    $rose(PENABLE) && PSEL && !PREADY;
  endsequence
  sequence s_plain;
    PIX_VALID && !CONSOLE_OPAQUE && !(CFG_CUR0_EN && CUR0_HIT) && !(CFG_CUR1_EN && CUR1_HIT);
  endsequence
  a_ready_wait: assert property (s_acc |=> PREADY) else $error("ready not after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_origin_bits: assert property (((CFG_ORIGIN0 | CFG_ORIGIN1) & ~`MSK_ADDR16) == 0)
    else $error("origin low or reserved bits set");
  a_pattern_bits: assert property (((CFG_CUR0_ADDR | CFG_CUR1_ADDR) & ~`MSK_ADDR16) == 0)
    else $error("pattern address low bits set");
  a_disp_even: assert property (CFG_DIRECT_COLOR |-> !(CFG_DISP_ADDR0[0] | CFG_DISP_ADDR1[0]))
    else $error("display address odd in direct mode");
  a_cursor_off: assert property (s_plain |=> OUT_RGB == $past(LOWER_RGB))
    else $error("hidden cursor shown");
  a_console_top: assert property (PIX_VALID && CONSOLE_OPAQUE && !CONSOLE_ALPHA && !CUR0_HIT && !CUR1_HIT
    |=> OUT_RGB == $past(CONSOLE_RGB)) else $error("console not on top");
  a_rgb_hold: assert property (!PIX_VALID |=> $stable(OUT_RGB)) else $error("colour moved while idle");
endmodule
bind overlay_cursor_blend_regs overlay_cursor_blend_regs_chk i_chk (.*);
`default_nettype wire

// File: verification/overlay_cursor_blend_regs_tb.sv
// Directed bench for the overlay register bank
`include "overlay_cfg.svh"
`default_nettype none
module overlay_cursor_blend_regs_tb
  import overlay_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] lw = 18'h00111, cn = 18'h02222, c0 = 18'h03333, c1 = 18'h04444;
  logic MCLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PIX_VALID = 1'h0;
  logic CONSOLE_OPAQUE = 1'h0, CONSOLE_ALPHA = 1'h0, CUR0_HIT = 1'h0, CUR1_HIT = 1'h0;
  logic [`APB_AW-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [7:0] CUR0_CODE = 8'h00;
  logic PREADY, PSLVERR, er, CFG_DIRECT_COLOR, OUT_VALID;
  logic [11:0] CFG_START_X, CFG_CUR0_X, CFG_CUR0_Y, CFG_CUR1_Y;
  logic [17:0] OUT_RGB;
  int mismatches = 0, n_compared = 0;
  logic [9:0] ix [16] = '{`IDX_BR_ORIGIN0, `IDX_BR_DISP0, `IDX_BR_ORIGIN1, `IDX_BR_DISP1, `IDX_BR_START_X,
    `IDX_BR_START_Y, `IDX_CUR_TRANSP, `IDX_CUR_PRIO, `IDX_CUR0_ADDR, `IDX_CUR0_X, `IDX_CUR0_Y,
    `IDX_CUR1_ADDR, `IDX_CUR1_X, `IDX_CUR1_Y, `IDX_BLEND_CTRL, `IDX_BLEND_MODE};
  logic [31:0] mk [16] = '{`MSK_ADDR16, `MSK_ADDR, `MSK_ADDR16, `MSK_ADDR, `MSK_POS, `MSK_POS, `MSK_TRANSP,
    `MSK_PRIO, `MSK_ADDR16, `MSK_POS, `MSK_POS, `MSK_ADDR16, `MSK_POS, `MSK_POS, `MSK_BLEND_CTRL, `MSK_BLEND_MODE};
  overlay_cursor_blend_regs i_dut (.*, .CFG_ORIGIN0(), .CFG_DISP_ADDR0(), .CFG_ORIGIN1(), .CFG_DISP_ADDR1(),
    .CFG_START_Y(), .CFG_CUR0_ADDR(), .CFG_CUR1_ADDR(), .CFG_CUR1_X(), .CFG_CUR0_EN(), .CFG_CUR1_EN(),
    .LOWER_RGB(lw), .CONSOLE_RGB(cn), .CUR0_RGB(c0), .CUR1_RGB(c1), .CUR1_CODE(8'h01));
  always #2 MCLK = ~MCLK;
  // ----------------------------------------
  // Bus, pixel and report tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= {i, 2'h0};
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'h1;
    // Look between edges so the flops have settled
    @(negedge MCLK);
    while (PREADY !== 1'h1 && n < 16) begin
      @(negedge MCLK);
      n++;
    end
    if (n >= 16) begin
      mismatches++;
      end_sim();
    end
    rd = PRDATA;
    er = PSLVERR;
    @(posedge MCLK);
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge MCLK);
  endtask
  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    apb(1'h0, i, 32'h0);
    chk(rd, e);
  endtask
  // Flags are opaque, alpha, cursor 0 hit, cursor 1 hit
  task automatic pix(input logic [3:0] f, input logic [7:0] k, input logic [17:0] e);
    {CONSOLE_OPAQUE, CONSOLE_ALPHA, CUR0_HIT, CUR1_HIT} <= f;
    CUR0_CODE <= k;
    PIX_VALID <= 1'h1;
    @(posedge MCLK);
    PIX_VALID <= 1'h0;
    @(negedge MCLK);
    chk({OUT_VALID, OUT_RGB}, {1'h1, e});
    @(posedge MCLK);
  endtask
  function automatic logic [17:0] bl(input int w);
    logic [17:0] r;
    for (int i = 0; i < 3; i++) r[i*6+:6] = 6'((cn[i*6+:6] * w + lw[i*6+:6] * (16 - w)) >> 4);
    return r;
  endfunction
  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'h0;
    @(posedge MCLK);
    for (int j = 0; j < 16; j++) begin
      rc(ix[j], 32'h0);
      apb(1'h1, ix[j], 32'hFFFF_FFFF);
      rc(ix[j], mk[j]);
    end
    chk({CFG_START_X, CFG_CUR0_X, CFG_CUR0_Y, CFG_CUR1_Y}, {4{12'hFFF}});
    apb(1'h1, `IDX_BR_MODE, 32'hFFFF_FFFF);
    rc(`IDX_BR_MODE, `MSK_BR_MODE);
    chk(CFG_DIRECT_COLOR, 1'h1);
    rc(`IDX_BR_DISP0, 32'h0FFF_FFFE);
    apb(1'h1, `IDX_BR_DISP1, 32'hFFFF_FFFF);
    rc(`IDX_BR_DISP1, 32'h0FFF_FFFE);
    apb(1'h1, `IDX_BR_MODE, 32'h0);
    chk(CFG_DIRECT_COLOR, 1'h0);
    apb(1'h1, 10'h0C0, 32'hFFFF_FFFF);
    chk(er, 1'h1);
    rc(10'h0C0, 32'h0);
    chk(er, 1'h1);
    apb(1'h1, `IDX_CUR_PRIO, 32'h0);
    pix(4'h3, 8'h05, lw);
    apb(1'h1, `IDX_CUR_PRIO, 32'h33);
    pix(4'hB, 8'h05, c0);
    pix(4'h9, 8'h05, c1);
    apb(1'h1, `IDX_CUR_PRIO, 32'h30);
    pix(4'hA, 8'h05, cn);
    pix(4'h3, 8'h05, c0);
    pix(4'h9, 8'h05, cn);
    apb(1'h1, `IDX_CUR_TRANSP, 32'h0AA);
    pix(4'h2, 8'h00, lw);
    pix(4'h2, 8'hAA, lw);
    apb(1'h1, `IDX_CUR_TRANSP, 32'h1AA);
    pix(4'h2, 8'h00, c0);
    apb(1'h1, `IDX_BLEND_MODE, 32'h0);
    pix(4'hC, 8'h05, cn);
    apb(1'h1, `IDX_BLEND_MODE, 32'h1);
    pix(4'h8, 8'h05, cn);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 16; k += 5) begin
        apb(1'h1, `IDX_BLEND_CTRL, {16'h0, s[0], 7'h0, k[3:0], 4'h0});
        pix(4'hC, 8'h05, bl(s == 1 ? 16 - k : k));
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
